//--- hdl/sgram_guard_pkg.sv
/*
  Constants, timing counts and carrier types for the command timing guard.
  Assumes a single 100 MHz core clock and commands decoded on that clock.
*/
// Notes on behaviour
// - Pending calibration applied soon after all-bank refresh.
// - Training data presented within latency after command.
// - Training off returns pins to termination quickly.
// - Auto precharge waits for activate-to-precharge minimum.
`default_nettype none
package sgram_guard_pkg;
  // ------------------------------------------------------------------
  // Clock and timing figures
  // ------------------------------------------------------------------
  localparam int TCK_PS                  = 10000;
  localparam int CALIB_UPDATE_LATENCY_NS = 12;  // Plus one clock
  localparam int TRAINING_OUTPUT_LAT_NS  = 12;  // Plus two clocks
  localparam int TRAINING_OFF_LAT_NS     = 12;  // Plus one clock
  localparam int ACT_TO_PRE_MIN_NS       = 34;
  localparam int MODESET_SPACING_NS      = 10;
  localparam int MODESET_SPACING_TCK     = 10;
  localparam int ENTRY_NOP_WINDOW_TCK    = 10;
  localparam int PWRDN_EXIT_WAIT_TCK     = 12;

  // Longest times round down, least times round up
  localparam int CALIB_LAT_CYC  = 1 + (CALIB_UPDATE_LATENCY_NS * 1000) / TCK_PS;
  localparam int TRAIN_OUT_CYC  = 2 + (TRAINING_OUTPUT_LAT_NS * 1000) / TCK_PS;
  localparam int TRAIN_OFF_CYC  = 1 + (TRAINING_OFF_LAT_NS * 1000) / TCK_PS;
  localparam int RAS_CYC        = (ACT_TO_PRE_MIN_NS * 1000 + TCK_PS - 1) / TCK_PS;
  localparam int MRD_NS_CYC     = (MODESET_SPACING_NS * 1000 + TCK_PS - 1) / TCK_PS;
  localparam int MRD_CYC        = (MRD_NS_CYC > MODESET_SPACING_TCK) ? MRD_NS_CYC
                                                                    : MODESET_SPACING_TCK;

  // ------------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------------
  localparam int NUM_BANKS   = 16;
  localparam int CA_W        = 10;
  localparam int STRAP_W     = 7;
  localparam int SPACE_CNT_W = 4;
  localparam logic [CA_W:0] TRAIN_DQ_RST = 11'h000;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_ACTIVE  = 3'b001,
    ST_PWRDN   = 3'b010,
    ST_SELFREF = 3'b100
  } power_state_t;

  // Decoded command strobes, one cycle each
  typedef struct packed {
    logic       activate;
    logic       read_ap;
    logic       write_ap;
    logic       all_bank_refresh;
    logic       powerdown_entry_cmd;
    logic       powerdown_exit_cmd;
    logic       selfrefresh_entry_cmd;
    logic       selfrefresh_exit_cmd;
    logic       modeset;
    logic       cmd_bus_training_cmd;
    logic       nop;
    logic [3:0] bank;
  } cmd_t;

  // Strap levels caught at reset release
  typedef struct packed {
    logic               error_detect_pin;
    logic [STRAP_W-1:0] ca_low;
  } strap_t;
endpackage
`default_nettype wire

//--- hdl/bank_autopre_timer.sv
/*
  Per-bank auto-precharge holdoff timer.
  Assumes activate and auto-precharge strobes decoded on the core clock.
*/
`default_nettype none
module bank_autopre_timer
  import sgram_guard_pkg::*;
#(
  parameter int HOLD_CYC = RAS_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Bank commands
  input  wire logic act_i,
  input  wire logic autopre_i,
  // Bank status
  output logic      open_o,
  output logic      precharge_o
);
  initial begin
    if (HOLD_CYC < 2 || HOLD_CYC > 15) $error("HOLD_CYC out of range");
  end

  logic [3:0] cnt_ff, nxt_cnt;
  logic       pend_ff, nxt_pend;
  logic       open_ff, nxt_open;
  logic       pre_ff, nxt_pre;

  // ------------------------------------------------------------------
  // Holdoff count and deferred precharge
  // ------------------------------------------------------------------
  // Count is loaded two short so the registered strobe lands on time
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_pend = pend_ff;
    nxt_open = open_ff;
    nxt_pre  = 1'b0;
    if (cnt_ff != 4'h0) nxt_cnt = cnt_ff - 4'h1;
    if (autopre_i) nxt_pend = 1'b1;
    if (pend_ff && open_ff && cnt_ff == 4'h0) begin
      nxt_pre  = 1'b1;
      nxt_pend = autopre_i;
      nxt_open = 1'b0;
    end
    if (act_i) begin
      nxt_cnt  = 4'(HOLD_CYC - 2);
      nxt_open = 1'b1;
      nxt_pend = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff  <= 4'h0;
      pend_ff <= 1'b0;
      open_ff <= 1'b0;
      pre_ff  <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      pend_ff <= nxt_pend;
      open_ff <= nxt_open;
      pre_ff  <= nxt_pre;
    end
  end

  assign open_o      = open_ff;
  assign precharge_o = pre_ff;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  pre_holdoff_a: assert property (act_i |=> !precharge_o [*3])
    else $error("precharge inside activate holdoff");
  pre_cause_a: assert property (precharge_o |-> $past(pend_ff) && !open_o)
    else $error("precharge without pending auto precharge");
  pre_seen_c: cover property (act_i ##1 autopre_i ##[1:6] precharge_o);
endmodule
`default_nettype wire

//--- hdl/sgram_command_timing_guard.sv
/*
  Device-side command timing guard: calibration update on all-bank
  refresh, address training capture, auto-precharge holdoff, low-power
  state tracking, sequence checking and strap capture.
  Assumes commands arrive decoded on the core clock; strap pins are async.
*/
`default_nettype none
module sgram_command_timing_guard
  import sgram_guard_pkg::*;
#(
  parameter int BANKS = NUM_BANKS
) (
  // Clock and reset
  input  wire logic              CORE_CLK_I,
  input  wire logic              RST_I,
  // Decoded command path
  input  wire cmd_t              CMD_I,
  input  wire logic [CA_W-1:0]   CA_I,
  input  wire logic              CMD_BUS_INVERT_N_I,
  // Modes and internal requests
  input  wire logic              CMD_BUS_TRAINING_MODE_I,
  input  wire logic              CALIB_REQ_I,
  input  wire logic              SEQ_ERR_CLR_I,
  // Strap pins
  input  wire strap_t            STRAP_I,
  // Training outputs
  output logic [CA_W:0]          TRAIN_DQ_O,
  output logic                   TRAIN_DQ_OE_N_O,
  // Status
  output logic                   CALIB_APPLY_O,
  output logic                   CALIB_PENDING_O,
  output logic [BANKS-1:0]       BANK_OPEN_O,
  output logic [BANKS-1:0]       BANK_PRECHARGE_O,
  output power_state_t           POWER_STATE_O,
  output logic                   SEQ_ERR_O,
  output strap_t                 STRAP_O
);
  initial begin
    if (BANKS != NUM_BANKS) $error("BANKS must match the bank field");
  end

  // ------------------------------------------------------------------
  // Calibration update on all-bank refresh
  // ------------------------------------------------------------------
  logic calib_pend_ff, nxt_calib_pend;
  logic calib_apply_ff, nxt_calib_apply;

  // New request wins over the clear in the apply cycle
  always_comb begin
    nxt_calib_apply = CMD_I.all_bank_refresh && calib_pend_ff;
    nxt_calib_pend  = calib_pend_ff;
    if (nxt_calib_apply) nxt_calib_pend = 1'b0;
    if (CALIB_REQ_I) nxt_calib_pend = 1'b1;
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      calib_pend_ff  <= 1'b0;
      calib_apply_ff <= 1'b0;
    end else begin
      calib_pend_ff  <= nxt_calib_pend;
      calib_apply_ff <= nxt_calib_apply;
    end
  end

  // ------------------------------------------------------------------
  // Address training capture and release
  // ------------------------------------------------------------------
  logic [CA_W:0] train_dq_ff, nxt_train_dq;
  logic          train_oe_n_ff, nxt_train_oe_n;

  // One cycle to drive, well inside both latency limits
  always_comb begin
    nxt_train_dq   = train_dq_ff;
    nxt_train_oe_n = train_oe_n_ff;
    if (!CMD_BUS_TRAINING_MODE_I) begin
      nxt_train_oe_n = 1'b1;
    end else if (CMD_I.cmd_bus_training_cmd) begin
      nxt_train_dq   = {CMD_BUS_INVERT_N_I, CA_I};
      nxt_train_oe_n = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      train_dq_ff   <= TRAIN_DQ_RST;
      train_oe_n_ff <= 1'b1;
    end else begin
      train_dq_ff   <= nxt_train_dq;
      train_oe_n_ff <= nxt_train_oe_n;
    end
  end

  // ------------------------------------------------------------------
  // Per-bank auto-precharge holdoff
  // ------------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      bank_autopre_timer #(
        .HOLD_CYC (RAS_CYC)
      ) u_timer (
        .clk_i       (CORE_CLK_I),
        .rst_i       (RST_I),
        .act_i       (CMD_I.activate && CMD_I.bank == 4'(b)),
        .autopre_i   ((CMD_I.read_ap || CMD_I.write_ap) && CMD_I.bank == 4'(b)),
        .open_o      (BANK_OPEN_O[b]),
        .precharge_o (BANK_PRECHARGE_O[b])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // Low-power state and command sequence checking
  // ------------------------------------------------------------------
  power_state_t           pstate_ff, nxt_pstate;
  logic [SPACE_CNT_W-1:0] nop_cnt_ff, nxt_nop_cnt;
  logic [SPACE_CNT_W-1:0] mrd_cnt_ff, nxt_mrd_cnt;
  logic                   seq_err_ff, nxt_seq_err;
  logic                   busy_cmd;

  // Any real command other than no-operation
  assign busy_cmd = CMD_I.activate | CMD_I.read_ap | CMD_I.write_ap
                  | CMD_I.all_bank_refresh | CMD_I.powerdown_entry_cmd
                  | CMD_I.powerdown_exit_cmd | CMD_I.selfrefresh_entry_cmd
                  | CMD_I.selfrefresh_exit_cmd | CMD_I.modeset
                  | CMD_I.cmd_bus_training_cmd;

  // The device only flags a bad controller; it never blocks commands
  always_comb begin
    nxt_pstate  = pstate_ff;
    nxt_nop_cnt = (nop_cnt_ff != '0) ? nop_cnt_ff - 1'b1 : nop_cnt_ff;
    nxt_mrd_cnt = (mrd_cnt_ff != '0) ? mrd_cnt_ff - 1'b1 : mrd_cnt_ff;
    nxt_seq_err = seq_err_ff && !SEQ_ERR_CLR_I;
    if (busy_cmd && nop_cnt_ff != '0) nxt_seq_err = 1'b1;
    if (CMD_I.modeset && mrd_cnt_ff != '0) nxt_seq_err = 1'b1;
    if (CMD_I.modeset) nxt_mrd_cnt = SPACE_CNT_W'(MRD_CYC - 1);
    case (pstate_ff)
      ST_ACTIVE: begin
        if (CMD_I.powerdown_entry_cmd) begin
          nxt_pstate  = ST_PWRDN;
          nxt_nop_cnt = SPACE_CNT_W'(ENTRY_NOP_WINDOW_TCK - 1);
        end else if (CMD_I.selfrefresh_entry_cmd) begin
          nxt_pstate  = ST_SELFREF;
          nxt_nop_cnt = SPACE_CNT_W'(ENTRY_NOP_WINDOW_TCK - 1);
        end
      end
      ST_PWRDN: begin
        if (CMD_I.powerdown_exit_cmd) begin
          nxt_pstate  = ST_ACTIVE;
          nxt_nop_cnt = SPACE_CNT_W'(PWRDN_EXIT_WAIT_TCK - 1);
        end
      end
      ST_SELFREF: begin
        if (CMD_I.selfrefresh_exit_cmd) begin
          nxt_pstate  = ST_ACTIVE;
          nxt_nop_cnt = SPACE_CNT_W'(PWRDN_EXIT_WAIT_TCK - 1);
        end
      end
      default: nxt_pstate = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      pstate_ff  <= ST_ACTIVE;
      nop_cnt_ff <= '0;
      mrd_cnt_ff <= '0;
      seq_err_ff <= 1'b0;
    end else begin
      pstate_ff  <= nxt_pstate;
      nop_cnt_ff <= nxt_nop_cnt;
      mrd_cnt_ff <= nxt_mrd_cnt;
      seq_err_ff <= nxt_seq_err;
    end
  end

  // ------------------------------------------------------------------
  // Strap capture at reset release
  // ------------------------------------------------------------------
  strap_t strap_meta_ff, strap_sync_ff, strap_ff, nxt_strap;
  logic   rst_seen_ff;

  // Straps are held around release, so the synced value is stable here
  always_comb begin
    nxt_strap = strap_ff;
    if (rst_seen_ff) nxt_strap = strap_sync_ff;
  end

  always_ff @(posedge CORE_CLK_I) begin
    strap_meta_ff <= STRAP_I;
    strap_sync_ff <= strap_meta_ff;
    rst_seen_ff   <= RST_I;
    if (RST_I) begin
      strap_ff <= '0;
    end else begin
      strap_ff <= nxt_strap;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign TRAIN_DQ_O      = train_dq_ff;
  assign TRAIN_DQ_OE_N_O = train_oe_n_ff;
  assign CALIB_APPLY_O   = calib_apply_ff;
  assign CALIB_PENDING_O = calib_pend_ff;
  assign POWER_STATE_O   = pstate_ff;
  assign SEQ_ERR_O       = seq_err_ff;
  assign STRAP_O         = strap_ff;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  calib_latency_a: assert property (CMD_I.all_bank_refresh && calib_pend_ff
                                    |=> CALIB_APPLY_O
                                        && (!CALIB_PENDING_O || $past(CALIB_REQ_I)))
    else $error("calibration not applied after refresh");
  calib_cause_a: assert property (CALIB_APPLY_O |-> $past(CMD_I.all_bank_refresh))
    else $error("calibration applied without refresh");
  train_output_a: assert property (CMD_BUS_TRAINING_MODE_I && CMD_I.cmd_bus_training_cmd
                                   |=> !TRAIN_DQ_OE_N_O
                                       && TRAIN_DQ_O == $past({CMD_BUS_INVERT_N_I, CA_I}))
    else $error("training data not presented");
  train_off_a: assert property (!CMD_BUS_TRAINING_MODE_I |=> TRAIN_DQ_OE_N_O)
    else $error("training pins not released");
  entry_nop_a: assert property (CMD_I.powerdown_entry_cmd && pstate_ff == ST_ACTIVE
                                ##1 busy_cmd |=> SEQ_ERR_O)
    else $error("entry window violation not flagged");
  exit_nop_a: assert property (CMD_I.powerdown_exit_cmd && pstate_ff == ST_PWRDN
                               ##11 busy_cmd |=> SEQ_ERR_O)
    else $error("exit wait violation not flagged");
  modeset_gap_a: assert property (CMD_I.modeset ##9 CMD_I.modeset |=> SEQ_ERR_O)
    else $error("modeset spacing violation not flagged");
  err_sticky_a: assert property (SEQ_ERR_O && !SEQ_ERR_CLR_I |=> SEQ_ERR_O)
    else $error("sequence error lost");

  calib_seen_c: cover property (CALIB_REQ_I ##[1:20] CALIB_APPLY_O);
  train_seen_c: cover property (CMD_I.cmd_bus_training_cmd ##1 !TRAIN_DQ_OE_N_O
                                ##[1:10] TRAIN_DQ_OE_N_O);
  pwrdn_seen_c: cover property (pstate_ff == ST_PWRDN ##[1:40] pstate_ff == ST_ACTIVE);
  selfref_seen_c: cover property (pstate_ff == ST_SELFREF);
endmodule
`default_nettype wire

//--- tb/ctrl_model.sv
/*
  Controller stand-in: issues decoded commands and holds the strap pins.
  Assumes the bench calls its tasks from one process, just after a clock edge.
*/
`default_nettype none
module ctrl_model
  import sgram_guard_pkg::*;
(
  // Clock
  input  wire logic            clk_i,
  // Command side
  output cmd_t                 cmd_o,
  output logic [CA_W-1:0]      ca_o,
  output logic                 inv_n_o,
  // Strap pins
  output strap_t               strap_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // Bus idle and command issue
  // ------------------------------------------------------------
  // Sparse traffic only: no refresh backlog, few activates, no data
  // No lock, hibernate or supply sequencing is ever requested
  initial begin
    cmd_o     = '0;
    cmd_o.nop = 1'b1;
    ca_o      = 10'h3FF;
    inv_n_o   = 1'b1;
    strap_o   = '0;
  end

  // Straps stay put across the whole reset release
  task automatic set_strap(input strap_t v);
    strap_o = v;
  endtask

  // One command cycle; CA returns high afterwards so few inputs idle low
  task automatic send(input cmd_t c, input logic [CA_W:0] d);
    @(posedge clk_i);
    #1;
    cmd_o   = c;
    inv_n_o = d[CA_W];
    ca_o    = d[CA_W-1:0];  // Few low bits on CA
    @(posedge clk_i);
    #1;
    cmd_o     = '0;
    cmd_o.nop = 1'b1;
    inv_n_o   = 1'b1;  // Inversion high while idle
    ca_o      = 10'h3FF;
  endtask

  // Idle cycles between commands; returns just after an edge like send
  task automatic quiet(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

//--- tb/sgram_command_timing_guard_tb_top.sv
/*
  Self-checking bench for the command timing guard.
  Assumes ctrl_model drives the command side and strap pins; the bench drives the rest.
*/
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module sgram_command_timing_guard_tb_top
  import sgram_guard_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // Signals, clock and instances
  // ------------------------------------------------------------
  localparam int b_act = 14, b_rap = 13, b_wap = 12, b_ref = 11, b_pd_in = 10;
  localparam int b_pd_out = 9, b_sr_in = 8, b_sr_out = 7, b_mset = 6, b_train = 5;
  logic              clk;
  logic              rst;
  cmd_t              cmd;
  logic [CA_W-1:0]   ca;
  logic              inv_n;
  logic              mode;
  logic              calib_req;
  logic              err_clr;
  strap_t            strap;
  logic [CA_W:0]     dq;
  logic              dq_oe_n;
  logic              apply;
  logic              pending;
  logic [15:0]       bank_open;
  logic [15:0]       bank_pre;
  power_state_t      pstate;
  logic              seq_err;
  strap_t            strap_q;
  int                error_cnt;
  int                check_count;
  int                cyc;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ctrl_model ctrl_model_inst (
    .clk_i(clk), .cmd_o(cmd), .ca_o(ca), .inv_n_o(inv_n), .strap_o(strap)
  );

  sgram_command_timing_guard #(.BANKS(16)) sgram_command_timing_guard_inst (
    .CORE_CLK_I(clk), .RST_I(rst), .CMD_I(cmd), .CA_I(ca), .CMD_BUS_INVERT_N_I(inv_n),
    .CMD_BUS_TRAINING_MODE_I(mode), .CALIB_REQ_I(calib_req), .SEQ_ERR_CLR_I(err_clr),
    .STRAP_I(strap), .TRAIN_DQ_O(dq), .TRAIN_DQ_OE_N_O(dq_oe_n), .CALIB_APPLY_O(apply),
    .CALIB_PENDING_O(pending), .BANK_OPEN_O(bank_open), .BANK_PRECHARGE_O(bank_pre),
    .POWER_STATE_O(pstate), .SEQ_ERR_O(seq_err), .STRAP_O(strap_q)
  );

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic issue(input int b, input logic [3:0] bk, input logic [CA_W:0] d);
    cmd_t c;
    c       = '0;
    c[b]    = 1'b1;
    c.bank  = bk;
    ctrl_model_inst.send(c, d);
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_calib();
    issue(b_ref, 4'h0, 11'h7FF);
    `CHK(apply, 1'b0)
    step();
    calib_req = 1'b1;
    step();
    calib_req = 1'b0;
    `CHK(pending, 1'b1)
    issue(b_ref, 4'h0, 11'h7FF);
    `CHK(apply, 1'b1)
    `CHK(pending, 1'b0)
    step();
    `CHK(apply, 1'b0)
    $display("test calib done");
  endtask

  task automatic test_train();
    step();
    mode = 1'b1;
    issue(b_train, 4'h0, 11'h7F3);
    `CHK(dq, 11'h7F3)
    `CHK(dq_oe_n, 1'b0)
    issue(b_train, 4'h0, 11'h3CF);
    `CHK(dq, 11'h3CF)
    mode = 1'b0;
    step();
    `CHK(dq_oe_n, 1'b1)
    issue(b_train, 4'h0, 11'h5FE);
    `CHK(dq, 11'h3CF)
    `CHK(dq_oe_n, 1'b1)
    $display("test train done");
  endtask

  // Early auto precharge waits out the holdoff; a late one fires at once
  task automatic test_bank();
    int c0;
    int n;
    issue(b_act, 4'h3, 11'h7FF);
    c0 = cyc;
    `CHK(bank_open[3], 1'b1)
    issue(b_rap, 4'h3, 11'h7FF);
    n = 0;
    while (bank_pre[3] !== 1'b1 && n < 8) begin
      step();
      n++;
    end
    `CHK(cyc - c0, RAS_CYC - 1)
    `CHK(bank_open[3], 1'b0)
    step();
    `CHK(bank_pre[3], 1'b0)
    issue(b_act, 4'hC, 11'h7FF);
    ctrl_model_inst.quiet(4);
    issue(b_wap, 4'hC, 11'h7FF);
    `CHK(bank_pre[12], 1'b0)
    step();
    `CHK(bank_pre[12], 1'b1)
    `CHK(bank_open[12], 1'b0)
    $display("test bank done");
  endtask

  // Legal spacing first, then a command on the last cycle of the power-down entry, mode-set and power-down exit windows
  task automatic test_seq();
    int kind [3] = '{b_pd_in, b_mset, b_pd_out};
    int wait_n [3] = '{7, 7, 9};
    issue(b_pd_in, 4'h0, 11'h7FF);
    `CHK(pstate, ST_PWRDN)
    ctrl_model_inst.quiet(8);
    issue(b_pd_out, 4'h0, 11'h7FF);
    `CHK(pstate, ST_ACTIVE)
    ctrl_model_inst.quiet(10);
    issue(b_sr_in, 4'h0, 11'h7FF);
    `CHK(pstate, ST_SELFREF)
    ctrl_model_inst.quiet(8);
    issue(b_sr_out, 4'h0, 11'h7FF);
    `CHK(pstate, ST_ACTIVE)
    ctrl_model_inst.quiet(10);
    issue(b_mset, 4'h0, 11'h7FF);
    ctrl_model_inst.quiet(8);
    issue(b_mset, 4'h0, 11'h7FF);
    ctrl_model_inst.quiet(8);
    `CHK(seq_err, 1'b0)
    for (int i = 0; i < 3; i++) begin
      issue(kind[i], 4'h0, 11'h7FF);
      ctrl_model_inst.quiet(wait_n[i]);
      // Only a second mode set breaks the mode-set spacing
      if (kind[i] == b_mset) begin
        issue(b_mset, 4'h0, 11'h7FF);
      end else begin
        issue(b_ref, 4'h0, 11'h7FF);
      end
      step();
      `CHK(seq_err, 1'b1)
      err_clr = 1'b1;
      step();
      err_clr = 1'b0;
      ctrl_model_inst.quiet(12);
      `CHK(seq_err, 1'b0)
    end
    $display("test seq done");
  endtask

  // Reset in mid-run clears the state and catches new strap levels
  task automatic test_reset();
    issue(b_pd_in, 4'h0, 11'h7FF);
    ctrl_model_inst.set_strap(8'h5A);
    rst = 1'b1;
    repeat (4) step();
    `CHK(pstate, ST_ACTIVE)
    `CHK(dq_oe_n, 1'b1)
    `CHK(strap_q, 8'h00)
    rst = 1'b0;
    step();
    step();
    `CHK(strap_q, 8'h5A)
    $display("test reset done");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst         = 1'b1;
    mode        = 1'b0;
    calib_req   = 1'b0;
    err_clr     = 1'b0;
    error_cnt   = 0;
    check_count = 0;
    cyc         = 0;
    #1;
    ctrl_model_inst.set_strap(8'hA5);
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    step();
    step();
    `CHK(strap_q, 8'hA5)
    $display("test strap done");
    test_calib();
    test_train();
    test_bank();
    test_seq();
    test_reset();
    close_out();
  end
endmodule
`undef CHK
`default_nettype wire
